// *** masked_step_sequencer.sv ***
// Masked step sequencer: stepping, timing, output pattern and error reporting
//
// Contract
// - Up to 16 steps, from a configurable first to a configurable final step.
// - Every step drives its mask-1 output bits, in both the 16 output bits and the packed output word.
// - Mask 1 loads the step pattern bit; mask 0 keeps the previous bit.
// - Rising advance edge between evaluations moves to the next step before the last.
// - Advance edge in last step sets done and copy, clears time, holds step.
// - Timed mode advances when the step event bit is set and time elapsed.
// - Step time is time base in ms times the step's time factor.
// - Remaining time decreases only while the step event bit is set.
// - Reset input high at an evaluation loads the first step number.
// - Timed mode with time base zero advances purely on event bits.
// - Advance edge steps at any time, timed mode or not.
// - Last step with expired time sets done and copy, holds until reset.
// - Step timer runs only in host startup or run states.
// - Cold restart reinitializes state at once, strobe or not.
// - Output bit j always equals bit j of the packed word.
// - Illegal final, current or first step freezes state, codes 8081/8082/8083.
// - Time product of 16-bit base and factor always fits 32 bits; code 8084 is never raised.
// - Duplicate end flag always equals the done flag.
// - Advance input is stored each error-free evaluation for edge detection.
`include "sequencer_defines.svh"
`default_nettype none

module masked_step_sequencer #(
  parameter int MS_TICK_CYCLES = `MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Evaluation control
  input wire logic eval_strobe_in,
  input wire logic sequencer_reset_in,
  input wire logic cold_restart_in,
  input wire sequencer_pkg::host_mode_type host_mode_in,
  // Stepping inputs
  input wire logic advance_pulse_in,
  input wire logic timed_mode_enable_in,
  input wire logic [`STEP_COUNT-1:0] step_event_in,
  // Step configuration
  input wire logic [`STEP_W-1:0] first_step_number_in,
  input wire logic [`STEP_W-1:0] final_step_number_in,
  input wire logic [`BASE_W-1:0] time_base_ms_in,
  input wire logic [`STEP_COUNT-1:0][`FACTOR_W-1:0] step_time_factor_in,
  input wire logic [`STEP_COUNT-1:0][`OUT_W-1:0] step_pattern_values_in,
  input wire logic [`STEP_COUNT-1:0][`OUT_W-1:0] step_mask_in,
  // Outputs
  output logic [`OUT_W-1:0] output_bit_out,
  output logic [`OUT_W-1:0] output_word_out,
  output logic done_out,
  output logic sequence_end_copy_out,
  output logic [15:0] error_code_out,
  output logic [`STEP_W-1:0] current_step_number_out,
  output logic [`TIME_W-1:0] remaining_step_time_out
);
  import sequencer_pkg::*;

  seq_state_type state;
  seq_state_type next_state;

  // Step number legal range check, shared by all three numbers
  function automatic logic step_legal(input logic [`STEP_W-1:0] step);
    step_legal = (step >= `STEP_FIRST_LEGAL) && (step <= `STEP_LAST_LEGAL);
  endfunction

  // Array index of a step number; only meaningful for legal numbers
  function automatic logic [3:0] step_index(input logic [`STEP_W-1:0] step);
    logic [`STEP_W-1:0] offset;
    offset = step - `STEP_ONE;
    step_index = offset[3:0];
  endfunction

  // Step time with one guard bit; it stays zero, as the 16 by 16 bit product always fits in 32 bits
  function automatic logic [`TIME_W:0] step_time(input logic [`BASE_W-1:0] base,
                                                 input logic [`FACTOR_W-1:0] factor);
    logic [`BASE_W+`FACTOR_W-1:0] product;
    product = base * factor;
    step_time = {1'b0, product};
  endfunction

  // Free-running millisecond time
  logic [`TIME_W-1:0] ms_now;

  ms_counter #(
    .TICK_CYCLES(MS_TICK_CYCLES)
  ) ms_counter_inst (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ms_count_out(ms_now)
  );

  // Step being entered: first step on reset, else the following step
  logic [`STEP_W-1:0] target_step;
  logic [3:0] target_index;
  logic [3:0] current_index;
  logic [`OUT_W-1:0] target_bits;

  assign target_step = sequencer_reset_in ? first_step_number_in
                                          : state.current_step_number + `STEP_ONE;
  assign target_index = step_index(target_step);
  assign current_index = step_index(state.current_step_number);

  output_mask_merge output_mask_merge_inst (
    .held_bits_in(state.output_bits),
    .pattern_bits_in(step_pattern_values_in[target_index]),
    .mask_bits_in(step_mask_in[target_index]),
    .merged_bits_out(target_bits)
  );

  // Range checks of the configured and current step numbers
  logic final_ok;
  logic first_ok;
  logic current_ok;

  assign final_ok = step_legal(final_step_number_in);
  assign first_ok = step_legal(first_step_number_in);
  assign current_ok = step_legal(state.current_step_number);

  // Time products of the step in force and of the step being entered
  logic [`TIME_W:0] current_time;
  logic [`TIME_W:0] target_time;
  logic time_overflow;

  assign current_time = step_time(time_base_ms_in, step_time_factor_in[current_index]);
  assign target_time = step_time(time_base_ms_in, step_time_factor_in[target_index]);
  assign time_overflow = sequencer_reset_in ? target_time[`TIME_W] : current_time[`TIME_W];

  // Edge, timing and position terms
  logic advance_edge;
  logic timer_running;
  logic step_event;
  logic at_final;
  logic [`TIME_W-1:0] elapsed_ms;
  logic time_expired;

  assign advance_edge = advance_pulse_in && !state.advance_history;
  assign timer_running = (host_mode_in == HOST_STARTUP) || (host_mode_in == HOST_RUN);
  assign step_event = step_event_in[current_index];
  assign at_final = state.current_step_number == final_step_number_in;
  assign elapsed_ms = ms_now - state.last_eval_ms;
  assign time_expired = state.remaining_step_time <= elapsed_ms;

  // Next-state logic, one evaluation per strobe
  always_comb
  begin
    next_state = state;
    if (cold_restart_in)
    begin
      next_state.current_step_number = `STEP_NONE;
      next_state.remaining_step_time = `TIME_ZERO;
      next_state.done = 1'b0;
      next_state.sequence_end_copy = 1'b0;
      next_state.output_bits = `OUT_RESET;
      next_state.advance_history = 1'b0;
      next_state.last_eval_ms = ms_now;
      next_state.error_code = `ERR_NONE;
    end
    else if (eval_strobe_in)
    begin
      if (!final_ok)
      begin
        next_state.error_code = `ERR_BAD_FINAL;
      end
      else if (!current_ok && !sequencer_reset_in)
      begin
        next_state.error_code = `ERR_BAD_CURRENT;
      end
      else if (!first_ok)
      begin
        next_state.error_code = `ERR_BAD_FIRST;
      end
      else if (time_overflow)
      begin
        next_state.error_code = `ERR_TIME_OVERFLOW;
      end
      else
      begin
        next_state.error_code = `ERR_NONE;
        next_state.advance_history = advance_pulse_in;
        next_state.last_eval_ms = ms_now;
        if (sequencer_reset_in)
        begin
          next_state.current_step_number = first_step_number_in;
          next_state.remaining_step_time = target_time[`TIME_W-1:0];
          next_state.done = 1'b0;
          next_state.sequence_end_copy = 1'b0;
          next_state.output_bits = target_bits;
        end
        else if (state.done)
        begin
          // Finished sequence waits for reset; outputs hold
          next_state.remaining_step_time = `TIME_ZERO;
        end
        else if (advance_edge)
        begin
          if (at_final)
          begin
            next_state.done = 1'b1;
            next_state.sequence_end_copy = 1'b1;
            next_state.remaining_step_time = `TIME_ZERO;
          end
          else
          begin
            next_state.current_step_number = target_step;
            next_state.remaining_step_time = target_time[`TIME_W-1:0];
            next_state.output_bits = target_bits;
          end
        end
        else if (timed_mode_enable_in && step_event && timer_running)
        begin
          if (time_expired)
          begin
            if (at_final)
            begin
              next_state.done = 1'b1;
              next_state.sequence_end_copy = 1'b1;
              next_state.remaining_step_time = `TIME_ZERO;
            end
            else
            begin
              next_state.current_step_number = target_step;
              next_state.remaining_step_time = target_time[`TIME_W-1:0];
              next_state.output_bits = target_bits;
            end
          end
          else
          begin
            next_state.remaining_step_time = state.remaining_step_time - elapsed_ms;
          end
        end
        // Without an event, or with the timer frozen, time holds
      end
    end
  end

  // State register; step number zero until the first reset evaluation
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // bits and word from one register
  assign output_bit_out = state.output_bits;
  // packed word of the same bits
  assign output_word_out = state.output_bits;
  assign done_out = state.done;
  assign sequence_end_copy_out = state.sequence_end_copy;
  assign error_code_out = state.error_code;
  assign current_step_number_out = state.current_step_number;
  assign remaining_step_time_out = state.remaining_step_time;

endmodule

`default_nettype wire

// *** masked_step_sequencer_tb_top.sv ***
// Self-checking bench for the masked step sequencer
`default_nettype none

module masked_step_sequencer_tb_top
  import sequencer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0, rst_n = 1'b0, stb = 1'b0, seq_rst = 1'b0, cold = 1'b0;
  logic adv = 1'b0, timed = 1'b0;
  host_mode_type host = HOST_RUN;
  logic [15:0] events = 16'h0000, base = 16'h0000, exp_out = 16'h0000;
  logic [7:0] first = 8'h01, final_step = 8'h03;
  logic [15:0][15:0] fac, pat, msk;
  logic [15:0] obit, oword, err;
  logic done, copy;
  logic [7:0] cur;
  logic [31:0] rem;
  int bad_count = 0, checked = 0;

  seq_app_model app (.factor_out(fac), .pattern_out(pat), .mask_out(msk));
  masked_step_sequencer #(.MS_TICK_CYCLES(4)) DUT (.clock_in(clock_in), .rst_n_in(rst_n),
    .eval_strobe_in(stb), .sequencer_reset_in(seq_rst), .cold_restart_in(cold),
    .host_mode_in(host), .advance_pulse_in(adv), .timed_mode_enable_in(timed),
    .step_event_in(events), .first_step_number_in(first), .final_step_number_in(final_step),
    .time_base_ms_in(base), .step_time_factor_in(fac), .step_pattern_values_in(pat),
    .step_mask_in(msk), .output_bit_out(obit), .output_word_out(oword), .done_out(done),
    .sequence_end_copy_out(copy), .error_code_out(err), .current_step_number_out(cur),
    .remaining_step_time_out(rem));

  // 20 MHz clock
  initial
  begin
    forever #25 clock_in = ~clock_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One evaluation; outputs settled by the next falling edge
  task automatic ev(input logic r, input logic a);
    @(negedge clock_in);
    seq_rst = r;
    adv = a;
    stb = 1'b1;
    @(negedge clock_in);
    stb = 1'b0;
  endtask

  // Evaluate every cycle until a step and done state show, or the limit runs out
  task automatic run(input int lim, input logic [7:0] step, input logic d);
    @(negedge clock_in);
    seq_rst = 1'b0;
    adv = 1'b0;
    stb = 1'b1;
    for (int i = 0; i < lim && !(cur === step && done === d); i++)
      @(negedge clock_in);
    stb = 1'b0;
  endtask

  function automatic logic [15:0] mrg(input logic [15:0] h, input int k);
    return (h & ~msk[k]) | (pat[k] & msk[k]);
  endfunction

  // Hang guard, well above the few hundred cycles the sequence needs
  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(negedge clock_in);
    rst_n = 1'b1;
    ev(1'b0, 1'b0);
    chk(err, 16'h8082);
    chk(cur, 8'h00);
    // Legal range kept by the caller except for the bad final and first step checks
    // legal limits
    ev(1'b1, 1'b0);
    exp_out = mrg(16'h0000, 0);
    chk(cur, 8'h01);
    chk(err, 16'h0000);
    chk(oword, exp_out);
    ev(1'b0, 1'b1);
    exp_out = mrg(exp_out, 1);
    chk(cur, 8'h02);
    chk(obit, exp_out);
    ev(1'b0, 1'b1);
    chk(cur, 8'h02);
    ev(1'b0, 1'b0);
    ev(1'b0, 1'b1);
    exp_out = mrg(exp_out, 2);
    chk(cur, 8'h03);
    chk(oword, exp_out);
    final_step = 8'h00;
    ev(1'b0, 1'b0);
    chk(err, 16'h8081);
    chk(cur, 8'h03);
    final_step = 8'h03;
    ev(1'b0, 1'b0);
    ev(1'b0, 1'b1);
    chk({done, copy, cur}, {2'b11, 8'h03});
    chk(rem, 32'h0000_0000);
    ev(1'b0, 1'b0);
    ev(1'b0, 1'b1);
    chk({done, cur, oword}, {1'b1, 8'h03, exp_out});
    first = 8'h11;
    ev(1'b1, 1'b0);
    chk({err, cur}, {16'h8083, 8'h03});
    first = 8'h01;
    @(negedge clock_in);
    cold = 1'b1;
    @(negedge clock_in);
    cold = 1'b0;
    chk({done, cur, oword}, {1'b0, 8'h00, 16'h0000});
    // Timed stepping, 1 ms base, step factors 1 and 2
    base = 16'h0001;
    final_step = 8'h02;
    timed = 1'b1;
    ev(1'b1, 1'b0);
    exp_out = mrg(16'h0000, 0);
    chk(rem, 32'h0000_0001);
    run(20, 8'hff, 1'b0);
    chk({cur, rem}, {8'h01, 32'h0000_0001});
    host = HOST_STOP;
    events = 16'h0001;
    run(20, 8'hff, 1'b0);
    chk({cur, rem}, {8'h01, 32'h0000_0001});
    // Startup state must let the timer run as well
    host = HOST_STARTUP;
    run(40, 8'h02, 1'b0);
    exp_out = mrg(exp_out, 1);
    chk({cur, rem}, {8'h02, 32'h0000_0002});
    chk(oword, exp_out);
    events = 16'h0003;
    host = HOST_RUN;
    run(60, 8'h02, 1'b1);
    chk({done, copy, rem}, {2'b11, 32'h0000_0000});
    // Zero base: event bits alone step, advance still works
    base = 16'h0000;
    events = 16'h0000;
    ev(1'b1, 1'b0);
    chk({done, cur, rem}, {1'b0, 8'h01, 32'h0000_0000});
    events = 16'h0001;
    ev(1'b0, 1'b0);
    chk(cur, 8'h02);
    events = 16'h0000;
    ev(1'b0, 1'b1);
    chk({done, cur}, {1'b1, 8'h02});
    end_sim();
  end
endmodule

`default_nettype wire

// *** ms_counter.sv ***
// Free-running millisecond counter driven by a tick divider
`include "sequencer_defines.svh"
`default_nettype none

module ms_counter #(
  parameter int TICK_CYCLES = `MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Millisecond count
  output logic [`TIME_W-1:0] ms_count_out
);
  import sequencer_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  ms_state_type state;
  ms_state_type next_state;

  // Divider wraps once per millisecond, then the count steps
  always_comb
  begin
    next_state = state;
    if (state.divider == TICK_LAST)
    begin
      next_state.divider = `TICK_ZERO;
      next_state.ms_count = state.ms_count + 32'h0000_0001; // Wraps freely
    end
    else
    begin
      next_state.divider = state.divider + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign ms_count_out = state.ms_count;

endmodule

`default_nettype wire

// *** output_mask_merge.sv ***
// Per-bit choice between a step pattern and the held output
`include "sequencer_defines.svh"
`default_nettype none

module output_mask_merge (
  // Held outputs and the step row
  input wire logic [`OUT_W-1:0] held_bits_in,
  input wire logic [`OUT_W-1:0] pattern_bits_in,
  input wire logic [`OUT_W-1:0] mask_bits_in,
  // Merged outputs
  output logic [`OUT_W-1:0] merged_bits_out
);

  // Mask 1 loads the pattern, mask 0 keeps the held bit
  assign merged_bits_out = (mask_bits_in & pattern_bits_in) | (~mask_bits_in & held_bits_in);

endmodule

`default_nettype wire

// *** seq_app_model.sv ***
// Application-side step tables feeding the sequencer
`default_nettype none

module seq_app_model (
  // Per-step tables
  output logic [15:0][15:0] factor_out,
  output logic [15:0][15:0] pattern_out,
  output logic [15:0][15:0] mask_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Fixed tables; odd rows (even step numbers) mask half the bits to exercise the hold path
  always_comb
  begin
    for (int k = 0; k < 16; k++)
    begin
      factor_out[k] = 16'(k + 1);
      pattern_out[k] = 16'(16'h1234 * (k + 1));
      mask_out[k] = k[0] ? 16'h0ff0 : 16'hffff;
    end
  end
endmodule

`default_nettype wire

// *** seq_checker.sv ***
// Port-level assertions for the masked step sequencer
`default_nettype none

module seq_checker
  import sequencer_pkg::*;
(
  // Clock, reset and controls
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic eval_strobe_in,
  input wire logic sequencer_reset_in,
  input wire logic cold_restart_in,
  input wire sequencer_pkg::host_mode_type host_mode_in,
  input wire logic advance_pulse_in,
  input wire logic timed_mode_enable_in,
  input wire logic [15:0] step_event_in,
  input wire logic [7:0] first_step_number_in,
  input wire logic [7:0] final_step_number_in,
  // Observed outputs
  input wire logic [15:0] output_bit_out,
  input wire logic [15:0] output_word_out,
  input wire logic done_out,
  input wire logic sequence_end_copy_out,
  input wire logic [15:0] error_code_out,
  input wire logic [7:0] current_step_number_out,
  input wire logic [31:0] remaining_step_time_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Helper terms for a clean evaluation
  logic ev, fin_ok, fst_ok, cur_ok, run_mode;
  assign ev = eval_strobe_in && !cold_restart_in;
  assign fin_ok = final_step_number_in inside {[8'h01:8'h10]};
  assign fst_ok = first_step_number_in inside {[8'h01:8'h10]};
  assign cur_ok = current_step_number_out inside {[8'h01:8'h10]};
  assign run_mode = host_mode_in == HOST_STARTUP || host_mode_in == HOST_RUN;

  out_bits_equal_a: assert property (output_bit_out == output_word_out)
    else $error("output bits differ from packed word");
  end_copy_equal_a: assert property (done_out == sequence_end_copy_out)
    else $error("end copy differs from done");
  reset_eval_a: assert property (ev && sequencer_reset_in && fin_ok && fst_ok |=>
    current_step_number_out == $past(first_step_number_in) && !done_out)
    else $error("reset evaluation missed first step");
  final_err_a: assert property (ev && !fin_ok |=> error_code_out == 16'h8081
    && $stable(current_step_number_out) && $stable(output_word_out))
    else $error("bad final step not refused");
  first_err_a: assert property (ev && fin_ok && sequencer_reset_in && !fst_ok |=>
    error_code_out == 16'h8083 && $stable(current_step_number_out))
    else $error("bad first step not refused");
  err_clear_a: assert property (ev && fin_ok && fst_ok && (sequencer_reset_in || cur_ok)
    |=> error_code_out == 16'h0000)
    else $error("error code not cleared");
  cold_restart_a: assert property (cold_restart_in |=> current_step_number_out == 8'h00
    && !done_out) else $error("cold restart did not reinitialize");
  idle_hold_a: assert property (!eval_strobe_in && !cold_restart_in |=>
    $stable(current_step_number_out) && $stable(remaining_step_time_out))
    else $error("state moved without evaluation");
  mode_hold_a: assert property (ev && !sequencer_reset_in && !advance_pulse_in &&
    (!timed_mode_enable_in || !run_mode) |=> $stable(remaining_step_time_out)
    && $stable(current_step_number_out) && $stable(output_word_out))
    else $error("timer ran outside timed run");
  event_hold_a: assert property (ev && !sequencer_reset_in && !advance_pulse_in && cur_ok
    && !step_event_in[current_step_number_out - 8'h01] |=> $stable(remaining_step_time_out))
    else $error("time fell without event bit");
  done_stay_a: assert property (done_out && ev && !sequencer_reset_in |=> done_out
    && $stable(current_step_number_out) && remaining_step_time_out == 32'h0000_0000)
    else $error("done state left without reset");
  // Main scenarios reached
  cover property ($rose(done_out));
  cover property (error_code_out == 16'h8083);
  cover property (current_step_number_out == 8'h02 && timed_mode_enable_in);
endmodule

bind masked_step_sequencer seq_checker chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .eval_strobe_in(eval_strobe_in), .sequencer_reset_in(sequencer_reset_in),
  .cold_restart_in(cold_restart_in), .host_mode_in(host_mode_in),
  .advance_pulse_in(advance_pulse_in), .timed_mode_enable_in(timed_mode_enable_in),
  .step_event_in(step_event_in), .first_step_number_in(first_step_number_in),
  .final_step_number_in(final_step_number_in), .output_bit_out(output_bit_out),
  .output_word_out(output_word_out), .done_out(done_out),
  .sequence_end_copy_out(sequence_end_copy_out), .error_code_out(error_code_out),
  .current_step_number_out(current_step_number_out),
  .remaining_step_time_out(remaining_step_time_out));

`default_nettype wire

// *** sequencer_defines.svh ***
// Shared constants of the masked step sequencer
`ifndef SEQUENCER_DEFINES_SVH
`define SEQUENCER_DEFINES_SVH

// Step range and widths
`define STEP_COUNT 16
`define STEP_FIRST_LEGAL 8'h01
`define STEP_LAST_LEGAL 8'h10
`define STEP_ONE 8'h01
`define STEP_NONE 8'h00
`define STEP_W 8
`define OUT_W 16
`define BASE_W 16
`define FACTOR_W 16
`define TIME_W 32

// Error codes on the error output
`define ERR_NONE 16'h0000
`define ERR_BAD_FINAL 16'h8081
`define ERR_BAD_CURRENT 16'h8082
`define ERR_BAD_FIRST 16'h8083
`define ERR_TIME_OVERFLOW 16'h8084

// Millisecond tick timing
`define CLOCK_PERIOD_NS 50
`define MS_PERIOD_NS 1000000
`define MS_TICK_CYCLES (`MS_PERIOD_NS / `CLOCK_PERIOD_NS)

// Reset values
`define OUT_RESET 16'h0000
`define TIME_ZERO 32'h0000_0000
`define TICK_ZERO 16'h0000

`endif

// *** sequencer_pkg.sv ***
// Types shared by the masked step sequencer
`include "sequencer_defines.svh"
`default_nettype none

package sequencer_pkg;

  // Operating state of the host system
  typedef enum logic [1:0] {
    HOST_STOP,
    HOST_STARTUP,
    HOST_RUN,
    HOST_HALT
  } host_mode_type;

  // Complete registered state of the sequencer
  typedef struct packed {
    logic [`STEP_W-1:0] current_step_number;
    logic [`TIME_W-1:0] remaining_step_time;
    logic done;
    logic sequence_end_copy;
    logic [`OUT_W-1:0] output_bits;
    logic advance_history;
    logic [`TIME_W-1:0] last_eval_ms;
    logic [15:0] error_code;
  } seq_state_type;

  // State of the millisecond counter
  typedef struct packed {
    logic [15:0] divider;
    logic [`TIME_W-1:0] ms_count;
  } ms_state_type;

endpackage

`default_nettype wire
